// File: rtl/drive_ind.sv
// Drive status indicator, locked-rotor detector and APB register slave
module drive_ind #(
   parameter int TICK_CYC = drive_ind_pkg::TICK_CYC  // Cycles per ms tick
) (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Motion feedback
   input  wire logic [15:0]           lead_lag_mag,
   // Supply and network condition
   input  wire drive_ind_pkg::pwr_t   pwr,
   input  wire drive_ind_pkg::can_t   can,
   input  wire drive_ind_pkg::nmt_t   nmt,
   // Drive and indicator outputs
   output logic                       power_stage_en,
   output logic                       locked_rotor_err,
   output logic                       pwr_led_green,
   output logic                       pwr_led_red,
   output logic                       net_led_green,
   output logic                       net_led_red,
   output logic                       irq
);
   // ====================
   // State
   drive_ind_pkg::st_t st;   // Registered state
   drive_ind_pkg::st_t nx;   // Next state
   logic       acc;          // APB access cycle
   logic       wr;           // Write access
   logic [3:0] ev;           // Event set pulses
   logic [1:0] want;         // Flash count wanted
   logic       red_sel;      // Red pattern chosen
   logic       red_solid;    // Red steady
   logic       grn_solid;    // Green steady
   logic       grn_blink;    // Green continuous flash
   logic       trip;         // Lock condition now
   logic       lock_tmo;     // Timeout expired

   // ====================
   // Next-state logic
   always_comb
   begin
      nx = st;
      ev = 4'h0;
      // Millisecond timebase
      nx.tick = 1'b0;
      if (st.tcnt == 16'(TICK_CYC - 1))
      begin
         nx.tcnt = 16'h0000;
         nx.tick = 1'b1;
      end
      else
      begin
         nx.tcnt = st.tcnt + 16'h0001;
      end
      // Locked-rotor timer runs while rotor lags
      if (st.hyb_en && lead_lag_mag != 16'h0000)
      begin
         if (st.tick && st.lms != 16'hffff)
         begin
            nx.lms = st.lms + 16'h0001;
         end
      end
      else
      begin
         nx.lms = 16'h0000;
      end
      lock_tmo = (st.lto != 16'h0000) && (st.lms >= st.lto);
      nx.over  = lead_lag_mag > st.dlim;
      trip = st.hyb_en && (nx.over || lock_tmo);
      // APB access phase, one wait state
      acc = psel && penable && !st.pready;
      wr  = acc && pwrite;
      nx.pready  = acc;
      nx.pslverr = 1'b0;
      // Register writes
      if (wr && paddr == drive_ind_pkg::A_CTRL)
      begin
         nx.hyb_en = pwdata[drive_ind_pkg::C_HYB];
         nx.drv_en = pwdata[drive_ind_pkg::C_DRV];
      end
      else if (wr && paddr == drive_ind_pkg::A_DLIM)
      begin
         nx.dlim = pwdata[15:0];
      end
      else if (wr && paddr == drive_ind_pkg::A_LTO)
      begin
         nx.lto = pwdata[15:0];
      end
      else if (wr && paddr == drive_ind_pkg::A_SYNC)
      begin
         nx.sto = pwdata[15:0];
      end
      else if (wr && paddr == drive_ind_pkg::A_IMSK)
      begin
         nx.imsk = pwdata[3:0];
      end
      // Lock error: set wins over clear
      if (trip)
      begin
         nx.lock = 1'b1;
         ev[drive_ind_pkg::I_LOCK] = !st.lock;
      end
      else if (!st.hyb_en || (wr && paddr == drive_ind_pkg::A_CTRL
                              && pwdata[drive_ind_pkg::C_CLR]))
      begin
         nx.lock = 1'b0;
      end
      nx.pstage = nx.drv_en && !nx.lock;
      // Sync supervision
      if (can.sync_rx || st.sto == 16'h0000)
      begin
         nx.sms   = 16'h0000;
         nx.slost = 1'b0;
      end
      else if (st.tick && !st.slost)
      begin
         nx.sms = st.sms + 16'h0001;
         if (nx.sms >= st.sto)
         begin
            nx.slost = 1'b1;
            ev[drive_ind_pkg::I_SYNC] = 1'b1;
         end
      end
      // Network events
      ev[drive_ind_pkg::I_GRD]  = can.guard_ev || can.hb_ev;
      nx.boff_q = can.bus_off;
      ev[drive_ind_pkg::I_BOFF] = can.bus_off && !st.boff_q;
      // Status W1C, event set wins
      if (wr && paddr == drive_ind_pkg::A_IST)
      begin
         nx.ist = (st.ist & ~pwdata[3:0]) | ev;
      end
      else
      begin
         nx.ist = st.ist | ev;
      end
      nx.irq = |(nx.ist & nx.imsk);
      // Register reads
      if (acc && !pwrite)
      begin
         nx.prdata = 32'h0000_0000;
         if (paddr == drive_ind_pkg::A_CTRL)
         begin
            nx.prdata[drive_ind_pkg::C_HYB] = st.hyb_en;
            nx.prdata[drive_ind_pkg::C_DRV] = st.drv_en;
         end
         else if (paddr == drive_ind_pkg::A_DLIM)
         begin
            nx.prdata[15:0] = st.dlim;
         end
         else if (paddr == drive_ind_pkg::A_LTO)
         begin
            nx.prdata[15:0] = st.lto;
         end
         else if (paddr == drive_ind_pkg::A_CLST)
         begin
            nx.prdata[drive_ind_pkg::S_LOCK] = st.lock;
            nx.prdata[drive_ind_pkg::S_PWR]  = st.pstage;
            nx.prdata[drive_ind_pkg::S_OVER] = st.over;
         end
         else if (paddr == drive_ind_pkg::A_ECODE)
         begin
            nx.prdata[15:0] = st.lock ? drive_ind_pkg::ERR_LOCK
                                      : drive_ind_pkg::ERR_NONE;
         end
         else if (paddr == drive_ind_pkg::A_SYNC)
         begin
            nx.prdata[15:0] = st.sto;
         end
         else if (paddr == drive_ind_pkg::A_IST)
         begin
            nx.prdata[3:0] = st.ist;
         end
         else if (paddr == drive_ind_pkg::A_IMSK)
         begin
            nx.prdata[3:0] = st.imsk;
         end
         else
         begin
            nx.pslverr = 1'b1;  // Unmapped
         end
      end
      else if (wr && paddr != drive_ind_pkg::A_CTRL && paddr != drive_ind_pkg::A_DLIM
               && paddr != drive_ind_pkg::A_LTO && paddr != drive_ind_pkg::A_SYNC
               && paddr != drive_ind_pkg::A_IST && paddr != drive_ind_pkg::A_IMSK)
      begin
         nx.pslverr = 1'b1;  // Unmapped or read-only
      end
      // Continuous flash phase
      if (st.tick)
      begin
         if (st.bms == drive_ind_pkg::FLASH_MS - 10'd1)
         begin
            nx.bms   = 10'h000;
            nx.blink = !st.blink;
         end
         else
         begin
            nx.bms = st.bms + 10'h001;
         end
      end
      // Network pattern by severity
      red_solid = 1'b0;
      red_sel   = 1'b1;
      grn_solid = 1'b0;
      grn_blink = 1'b0;
      want      = 2'd0;
      if (can.bus_off)
      begin
         red_solid = 1'b1;
      end
      else if (st.slost)
      begin
         want = 2'd3;
      end
      else if (st.ist[drive_ind_pkg::I_GRD])
      begin
         want = 2'd2;
      end
      else if (can.warn)
      begin
         want = 2'd1;
      end
      else
      begin
         red_sel = 1'b0;
         case (nmt)
            drive_ind_pkg::NMT_OPER:  grn_solid = 1'b1;
            drive_ind_pkg::NMT_STOP:  want = 2'd1;
            drive_ind_pkg::NMT_PREOP: grn_blink = 1'b1;
            default:                  grn_solid = 1'b0;
         endcase
      end
      // Flash group sequencer
      case (st.seq)
         drive_ind_pkg::SEQ_ON:
         begin
            if (st.tick)
            begin
               nx.qms = st.qms + 10'h001;
               if (st.qms == drive_ind_pkg::FLASH_MS - 10'd1)
               begin
                  nx.qms   = 10'h000;
                  nx.qleft = st.qleft - 2'd1;
                  nx.seq   = drive_ind_pkg::SEQ_OFF;
               end
            end
         end
         drive_ind_pkg::SEQ_OFF:
         begin
            if (st.tick)
            begin
               nx.qms = st.qms + 10'h001;
               if (st.qms == drive_ind_pkg::FLASH_MS - 10'd1)
               begin
                  nx.qms = 10'h000;
                  nx.seq = (st.qleft == 2'd0) ? drive_ind_pkg::SEQ_GAP
                                              : drive_ind_pkg::SEQ_ON;
               end
            end
         end
         default:
         begin
            if (st.tick)
            begin
               nx.qms = st.qms + 10'h001;
               if (st.qms >= drive_ind_pkg::GAP_MS - 10'd1 && want != 2'd0)
               begin
                  nx.qms   = 10'h000;
                  nx.qleft = want;
                  nx.seq   = drive_ind_pkg::SEQ_ON;
               end
               else if (st.qms >= drive_ind_pkg::GAP_MS - 10'd1)
               begin
                  nx.qms = st.qms;
               end
            end
         end
      endcase
      // Network indicator
      nx.nr = red_solid || (red_sel && want != 2'd0 && st.seq == drive_ind_pkg::SEQ_ON);
      nx.ng = grn_solid || (grn_blink && st.blink)
              || (!red_sel && want != 2'd0 && st.seq == drive_ind_pkg::SEQ_ON);
      // Power indicator
      nx.pg = (pwr.vdc_on && pwr.vdc_ok)
              || (!pwr.vdc_on && pwr.aux_on && pwr.aux_ok && st.blink);
      nx.pr = (pwr.vdc_on && !pwr.vdc_ok)
              || (!pwr.vdc_on && pwr.aux_on && !pwr.aux_ok && st.blink);
   end

   // ====================
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st     <= '0;
         st.seq <= drive_ind_pkg::SEQ_GAP;
         st.qms <= drive_ind_pkg::GAP_MS;
      end
      else
      begin
         st <= nx;
      end
   end

   // Outputs straight from flops
   assign prdata           = st.prdata;
   assign pready           = st.pready;
   assign pslverr          = st.pslverr;
   assign power_stage_en   = st.pstage;
   assign locked_rotor_err = st.lock;
   assign pwr_led_green    = st.pg;
   assign pwr_led_red      = st.pr;
   assign net_led_green    = st.ng;
   assign net_led_red      = st.nr;
   assign irq              = st.irq;

   // ====================
   // Assertions
   property p_trip;
      @(posedge pclk) disable iff (!presetn)
      st.hyb_en && lead_lag_mag > st.dlim |=> locked_rotor_err && !power_stage_en;
   endproperty
   a_trip: assert property (p_trip) else $error("Lock not raised on deviation");
   property p_nohyb;
      @(posedge pclk) disable iff (!presetn)
      !st.hyb_en |=> !locked_rotor_err;
   endproperty
   a_nohyb: assert property (p_nohyb) else $error("Lock without hybrid mode");
   property p_clst;
      @(posedge pclk) disable iff (!presetn)
      acc && !pwrite && paddr == drive_ind_pkg::A_CLST
      |=> prdata[drive_ind_pkg::S_LOCK] == $past(st.lock) && pready;
   endproperty
   a_clst: assert property (p_clst) else $error("Status read wrong");
   property p_pwr;
      @(posedge pclk) disable iff (!presetn)
      pwr.vdc_on && pwr.vdc_ok |=> pwr_led_green && !pwr_led_red;
   endproperty
   a_pwr: assert property (p_pwr) else $error("Power LED not green");
   property p_oper;
      @(posedge pclk) disable iff (!presetn)
      nmt == drive_ind_pkg::NMT_OPER && !can.bus_off && !can.warn && !st.slost
      && !st.ist[drive_ind_pkg::I_GRD] |=> net_led_green && !net_led_red;
   endproperty
   a_oper: assert property (p_oper) else $error("Operational not solid green");
   property p_boff;
      @(posedge pclk) disable iff (!presetn)
      can.bus_off |=> net_led_red && !net_led_green;
   endproperty
   a_boff: assert property (p_boff) else $error("Bus-off not solid red");
   property p_sync;
      @(posedge pclk) disable iff (!presetn)
      st.tick && !can.sync_rx && st.sto != 16'h0000 && st.sms == st.sto - 16'h0001
      |=> st.slost;
   endproperty
   a_sync: assert property (p_sync) else $error("Sync loss missed");
   property p_on;
      @(posedge pclk) disable iff (!presetn)
      st.seq == drive_ind_pkg::SEQ_ON && st.tick
      && st.qms == drive_ind_pkg::FLASH_MS - 10'd1 |=> st.seq == drive_ind_pkg::SEQ_OFF;
   endproperty
   a_on: assert property (p_on) else $error("Flash on time wrong");
endmodule : drive_ind

// File: rtl/drive_ind_pkg.sv
// Constants, types and the state record of the drive status and fault indicator
// Contract
// - Deviation or timeout trips power stage, error
// - Locked-rotor error only with hybrid mode enabled
// - Report lock in status bits and code
// - Two indicators: supply state, network state
// - Power indicator colours follow supply conditions
// - Operational state shows solid green
// - Stopped state shows single green flash
// - Pre-operational state shows continuous green flashing
// - Bus-off shows solid red
// - Error counter warning shows single red flash
// - Guard or heartbeat event: double red
// - Missing sync within period: triple red
// - Stopped shaft in hybrid mode raises error
package drive_ind_pkg;
   // ==================== Timing
   localparam int CLK_HZ   = 40_000_000;                // System clock rate
   localparam int TICK_MS  = 1;                         // Timebase tick in ms
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;   // Cycles per tick
   localparam logic [9:0] FLASH_MS = 10'd200;           // Flash on or off time
   localparam logic [9:0] GAP_MS   = 10'd1000;          // Gap between groups
   // ==================== Register map
   localparam logic [7:0] A_CTRL  = 8'h00;  // Control
   localparam logic [7:0] A_DLIM  = 8'h04;  // Lead/lag limit
   localparam logic [7:0] A_LTO   = 8'h08;  // Locked-rotor timeout, ms
   localparam logic [7:0] A_CLST  = 8'h0c;  // Closed-loop status
   localparam logic [7:0] A_ECODE = 8'h10;  // Error code
   localparam logic [7:0] A_SYNC  = 8'h14;  // Sync period timeout, ms
   localparam logic [7:0] A_IST   = 8'h18;  // Interrupt status, W1C
   localparam logic [7:0] A_IMSK  = 8'h1c;  // Interrupt mask
   // ==================== Fields
   localparam int C_HYB = 0;   // Hybrid mode enable
   localparam int C_DRV = 1;   // Power stage enable request
   localparam int C_CLR = 2;   // Fault clear, self-clearing
   localparam int S_LOCK = 0;  // Status: locked-rotor error
   localparam int S_PWR  = 1;  // Status: power stage on
   localparam int S_OVER = 2;  // Status: deviation over limit
   localparam int I_LOCK = 0;  // Event: locked rotor
   localparam int I_GRD  = 1;  // Event: guard or heartbeat
   localparam int I_SYNC = 2;  // Event: sync lost
   localparam int I_BOFF = 3;  // Event: bus-off entered
   localparam logic [15:0] ERR_NONE = 16'h0000;  // No error
   localparam logic [15:0] ERR_LOCK = 16'h0001;  // Locked rotor code
   // ==================== Types
   typedef enum logic [1:0] {NMT_INIT = 2'b00, NMT_PREOP = 2'b01,
                             NMT_OPER = 2'b10, NMT_STOP  = 2'b11} nmt_t;
   typedef enum logic [1:0] {SEQ_ON = 2'b00, SEQ_OFF = 2'b01,
                             SEQ_GAP = 2'b10} seq_t;
   typedef struct packed {logic vdc_on; logic vdc_ok; logic aux_on; logic aux_ok;} pwr_t;
   typedef struct packed {logic bus_off; logic warn; logic guard_ev; logic hb_ev;
                          logic sync_rx;} can_t;
   typedef struct packed {
      logic        pready;  logic [31:0] prdata;  logic pslverr;
      logic        hyb_en;  logic drv_en;
      logic [15:0] dlim;    logic [15:0] lto;     logic [15:0] sto;
      logic        lock;    logic over;           logic pstage;
      logic [3:0]  ist;     logic [3:0]  imsk;    logic irq;
      logic [15:0] tcnt;    logic tick;
      logic [15:0] lms;     logic [15:0] sms;     logic slost;  logic boff_q;
      logic [9:0]  bms;     logic blink;
      seq_t        seq;     logic [9:0]  qms;     logic [1:0] qleft;
      logic        pg;      logic pr;             logic ng;     logic nr;
   } st_t;
endpackage : drive_ind_pkg

// File: verification/can_net_model.sv
// Network master and CAN bus model feeding node state and bus events
module can_net_model (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Commands from the bench
   input  wire drive_ind_pkg::nmt_t nmt_cmd,
   input  wire logic [1:0]          lvl_cmd,
   input  wire logic                guard_req,
   input  wire logic                hb_req,
   input  wire logic                sync_on,
   // Network side seen by the node
   output drive_ind_pkg::can_t      can,
   output drive_ind_pkg::nmt_t      nmt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] sdiv;  // Sync spacing count
   // ==================== Bus events
   // Levels follow commands; sync arrives every fourth cycle while enabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         can <= '0;
         nmt <= drive_ind_pkg::NMT_INIT;
         sdiv <= 2'h0;
      end
      else
      begin
         nmt <= nmt_cmd;
         can.bus_off <= lvl_cmd[1];
         can.warn <= lvl_cmd[0];
         can.guard_ev <= guard_req;
         can.hb_ev <= hb_req;
         can.sync_rx <= sync_on && (sdiv == 2'h0);
         sdiv <= sdiv + 2'h1;
      end
   end
endmodule : can_net_model

// File: verification/drive_status_fault_indicator_tb_top.sv
// Self-checking bench for the drive status and fault indicator
module drive_status_fault_indicator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 2;         // Cycles per ms in simulation
   localparam int F  = 200 * TK;  // Cycles of one flash half
   localparam int G  = 1000 * TK; // Cycles of the gap after a group
   // ==================== Signals
   logic                pclk, presetn, psel, penable, pwrite;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic                pready, pslverr, er, guard, hb, sync_on;
   logic [15:0]         mag;
   drive_ind_pkg::pwr_t pwr;
   drive_ind_pkg::can_t can;
   drive_ind_pkg::nmt_t nmt, nmt_cmd;
   logic [1:0]          lvl;
   logic                pstage, lock_err, pg, pr, ng, nr, irq;
   wire logic [3:0]     leds = {nr, ng, pr, pg};  // LED select order
   int                  fails, comparisons, cyc;
   // ==================== Instances
   drive_ind #(.TICK_CYC(TK)) drive_ind_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lead_lag_mag(mag), .pwr(pwr), .can(can),
      .nmt(nmt), .power_stage_en(pstage), .locked_rotor_err(lock_err),
      .pwr_led_green(pg), .pwr_led_red(pr), .net_led_green(ng), .net_led_red(nr), .irq(irq));
   can_net_model can_net_model_i (.pclk(pclk), .presetn(presetn), .nmt_cmd(nmt_cmd),
      .lvl_cmd(lvl), .guard_req(guard), .hb_req(hb), .sync_on(sync_on), .can(can), .nmt(nmt));
   // ==================== Tasks
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Counts, then verdict
   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Read and compare
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rd_chk
   // Count lit cycles; an expectation of -k asks for groups of k flashes
   task automatic led_chk(input int sel, input int exp);
      logic [31:0] c;
      int          k;
      int          n;
      c = 32'h0;
      k = (exp < 0) ? -exp : 0;
      // One whole group period holds exactly k lit flash halves
      n = (k > 0) ? 2 * k * F + G : 2 * F;
      repeat (2 * F + 100 + ((k > 0) ? n : 0)) @(posedge pclk);
      repeat (n) @(posedge pclk) c = c + {31'h0, leds[sel]};
      check(c, (k > 0) ? k * F : exp);
   endtask : led_chk
   // ==================== Clock and watchdog
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Cut a hang short
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   // ==================== Main sequence
   initial
   begin
      logic [3:0] ptab [5];
      int         gtab [5];
      int         rtab [5];
      ptab = '{4'h0, 4'hc, 4'h3, 4'h8, 4'h2};
      gtab = '{0, 2 * F, F, 0, 0};
      rtab = '{0, 0, 0, 2 * F, F};
      {presetn, psel, penable, pwrite, paddr, pwdata, mag, pwr} = '0;
      {lvl, guard, hb, sync_on, fails, comparisons, cyc} = '0;
      nmt_cmd = drive_ind_pkg::NMT_INIT;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(drive_ind_pkg::A_CLST, 32'h0);
      rd_chk(drive_ind_pkg::A_ECODE, 32'h0);
      rd_chk(8'h20, 32'h0);
      check({31'h0, er}, 32'h1);
      apb(1'b1, drive_ind_pkg::A_CLST, 32'hf);
      check({31'h0, er}, 32'h1);
      // Detector stays quiet with hybrid mode off
      apb(1'b1, drive_ind_pkg::A_DLIM, 32'ha);
      apb(1'b1, drive_ind_pkg::A_IMSK, 32'hf);
      apb(1'b1, drive_ind_pkg::A_CTRL, 32'h2);
      mag <= 16'h64;
      repeat (20) @(posedge pclk);
      check({31'h0, lock_err}, 32'h0);
      check({31'h0, pstage}, 32'h1);
      apb(1'b1, drive_ind_pkg::A_CTRL, 32'h3);
      repeat (3) @(posedge pclk);
      check({30'h0, lock_err, pstage}, 32'h2);
      check({31'h0, irq}, 32'h1);
      rd_chk(drive_ind_pkg::A_CLST, 32'h5);
      rd_chk(drive_ind_pkg::A_ECODE, 32'h1);
      mag <= 16'h0;
      apb(1'b1, drive_ind_pkg::A_CTRL, 32'h7);
      apb(1'b1, drive_ind_pkg::A_IST, 32'h1);
      rd_chk(drive_ind_pkg::A_IST, 32'h0);
      check({30'h0, lock_err, irq}, 32'h0);
      // Timeout path below the deviation limit
      apb(1'b1, drive_ind_pkg::A_LTO, 32'h5);
      mag <= 16'h3;
      repeat (4) @(posedge pclk);
      check({31'h0, lock_err}, 32'h0);
      repeat (40) @(posedge pclk);
      check({31'h0, lock_err}, 32'h1);
      mag <= 16'h0;
      apb(1'b1, drive_ind_pkg::A_CTRL, 32'h4);
      apb(1'b1, drive_ind_pkg::A_IST, 32'h1);
      // Supply indicator over every supply condition
      for (int i = 0; i < 5; i++)
      begin
         pwr <= ptab[i];
         led_chk(0, gtab[i]);
         led_chk(1, rtab[i]);
      end
      // Network indicator states
      led_chk(2, 0);
      nmt_cmd <= drive_ind_pkg::NMT_OPER;
      led_chk(2, 2 * F);
      nmt_cmd <= drive_ind_pkg::NMT_PREOP;
      led_chk(2, F);
      nmt_cmd <= drive_ind_pkg::NMT_STOP;
      led_chk(2, -1);
      lvl <= 2'h1;
      led_chk(3, -1);
      guard <= 1'b1;
      @(posedge pclk);
      guard <= 1'b0;
      led_chk(3, -2);
      rd_chk(drive_ind_pkg::A_IST, 32'h2);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, drive_ind_pkg::A_IST, 32'h2);
      apb(1'b1, drive_ind_pkg::A_SYNC, 32'h3);
      led_chk(3, -3);
      rd_chk(drive_ind_pkg::A_IST, 32'h4);
      sync_on <= 1'b1;
      lvl <= 2'h0;
      apb(1'b1, drive_ind_pkg::A_IST, 32'h4);
      led_chk(3, 0);
      // Bus-off outranks the warning and heartbeat red conditions
      lvl <= 2'h3;
      hb <= 1'b1;
      @(posedge pclk);
      hb <= 1'b0;
      led_chk(3, 2 * F);
      rd_chk(drive_ind_pkg::A_IST, 32'ha);
      tally_and_finish();
   end
endmodule : drive_status_fault_indicator_tb_top
